// *** inc/pmbus_fault_mask_strap_regs.svh ***
// command codes, lengths, field masks and reset values of the mask and strap registers
// assumes the includer compiles these as plain text macros
`ifndef PMBUS_FAULT_MASK_STRAP_REGS_SVH
`define PMBUS_FAULT_MASK_STRAP_REGS_SVH

`define CMD_SNAPSHOT_MASK   8'hd7
`define CMD_ALERT_MASK      8'hdb
`define CMD_STRAP_READBACK  8'hdd
`define CMD_LOOP_TUNING     8'hdf

`define LEN_SNAPSHOT_MASK   3'h2
`define LEN_ALERT_MASK      3'h7
`define LEN_STRAP_READBACK  3'h7
`define LEN_LOOP_TUNING     3'h4

// bus address is arbitrary, normally taken from an address strap
`define SMBUS_ADDR          7'h20

`define RST_SNAPSHOT_MASK   16'h0000
`define RST_ALERT_MASK      56'h00000000000000
`define USED_SNAPSHOT_MASK  16'h3cff
`define USED_ALERT_BYTE     8'h5f
`define USED_LOOP_TUNING    32'h01ffffff
`define STRAP_UNUSED_BYTE   8'hff
`define READ_PAST_END       8'hff

`define STRAP_LADDER_MAX    8'h1e
`define STRAP_TIED_LOW      8'hf1
`define STRAP_OPEN          8'hf2
`define STRAP_TIED_HIGH     8'hf3

`define BYTE_BITS           4'h8
`define NUM_PAGES           2

`endif

// *** inc/pmbus_fault_mask_strap_pkg.sv ***
// types shared by the mask/strap register bank
// assumes the regs header is compiled alongside
package pmbus_fault_mask_strap_pkg;

    typedef enum logic [2:0] {
        LS_IDLE,
        LS_RECV,
        LS_ACK,
        LS_SEND,
        LS_MACK
    } link_state_t;

    typedef enum logic [1:0] {
        AF_ADDR,
        AF_CMD,
        AF_DATA
    } recv_phase_t;

    typedef struct packed {
        logic [15:0] gain;
        logic [7:0]  residual;
        logic        enable;
    } loop_setting_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

endpackage : pmbus_fault_mask_strap_pkg

// *** hdl/bit_synchronizer.sv ***
// two-flop synchroniser for one level from outside the sys_clk domain
// assumes the input may change at any time relative to sys_clk
`timescale 1ns/1ns
module bit_synchronizer #(
    parameter logic RESET_VALUE = 1'b1
) (
    input  wire logic sys_clk,   // block clock
    input  wire logic reset_n,   // synchronous reset, active low
    input  wire logic async_in,  // raw pin level
    output logic      sync_out   // level safe to use in sys_clk domain
);
    logic meta;

    // only the second flop is read by anything else
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            meta     <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : bit_synchronizer

// *** hdl/pmbus_fault_mask_strap_regs.sv ***
// fault mask, alert mask, strap readback and loop tuning registers behind the management bus
// assumes scl/sda are open-drain pins oversampled by sys_clk (scl slower than 8 sys_clk periods)
// assumes strap codes and loop-tuning strap word are stable when reset is released
`timescale 1ns/1ns
`include "pmbus_fault_mask_strap_regs.svh"
module pmbus_fault_mask_strap_regs (
    input  wire logic                                    sys_clk,        // 10 MHz block clock
    input  wire logic                                    reset_n,        // sync reset, active low
    input  wire logic                                    scl_in,         // bus clock pin level
    input  wire logic                                    sda_in,         // bus data pin level
    output pmbus_fault_mask_strap_pkg::pin_drive_t       sda_drive,      // data pin drive
    output pmbus_fault_mask_strap_pkg::pin_drive_t       alert_output_pin, // alert pin drive
    input  wire logic                                    page_sel,       // current page
    input  wire logic [15:0]                             fault_event,    // fault pulses, mask layout
    input  wire logic [55:0]                             fault_class,    // live status class bits
    input  wire logic [47:0]                             strap_code,     // strap decoder bytes
    input  wire logic [31:0]                             strap_loop_tuning, // strap tuning word
    input  wire logic [15:0]                             auto_gain,      // automatic loop gain
    input  wire logic [7:0]                              auto_residual,  // automatic residual
    output logic                                         snapshot_start, // start capture, pulse
    output pmbus_fault_mask_strap_pkg::loop_setting_t [1:0] adaptive_loop_control // per page
);
    import pmbus_fault_mask_strap_pkg::*;

    typedef struct packed {
        logic               scl_d;
        logic               sda_d;
        link_state_t        st;
        recv_phase_t        phase;
        logic [3:0]         bitcnt;
        logic [7:0]         shreg;
        logic               addressed;
        logic               rw;
        logic               mack;
        logic [7:0]         cmd;
        logic [2:0]         idx;
        logic [55:0]        wbuf;
        logic               wpage;
        logic               sda_oe;
        logic               alert_oe;
        logic               snap;
        logic [15:0]        snapshot_capture_fault_mask;
        logic [55:0]        alert_pin_fault_mask;
        logic [47:0]        strap_pin_readback;
        logic [1:0][31:0]   loop_tuning_config;
        logic [1:0]         override;
        logic               strap_taken;
    } state_t;

    state_t s;
    state_t next_s;
    logic   scl_sync;
    logic   sda_sync;

    bit_synchronizer #(.RESET_VALUE(1'b1)) scl_sync_i (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (scl_in),
        .sync_out (scl_sync)
    );

    bit_synchronizer #(.RESET_VALUE(1'b1)) sda_sync_i (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (sda_in),
        .sync_out (sda_sync)
    );

    function automatic logic [2:0] cmd_len(input logic [7:0] c);
        case (c)
            `CMD_SNAPSHOT_MASK:  cmd_len = `LEN_SNAPSHOT_MASK;
            `CMD_ALERT_MASK:     cmd_len = `LEN_ALERT_MASK;
            `CMD_STRAP_READBACK: cmd_len = `LEN_STRAP_READBACK;
            `CMD_LOOP_TUNING:    cmd_len = `LEN_LOOP_TUNING;
            default:             cmd_len = 3'h0;
        endcase
    endfunction : cmd_len

    // multi-byte words go out low byte first; bytes past the end read as ff
    function automatic logic [7:0] read_byte(input state_t q, input logic pg);
        logic [63:0] word;
        word = 64'h0;
        case (q.cmd)
            `CMD_SNAPSHOT_MASK: word = {48'h0, q.snapshot_capture_fault_mask};
            `CMD_ALERT_MASK:    word = {8'h0, q.alert_pin_fault_mask};
            `CMD_STRAP_READBACK: word = {8'h0, q.strap_pin_readback, `STRAP_UNUSED_BYTE};
            `CMD_LOOP_TUNING:   word = {32'h0, q.loop_tuning_config[pg]};
            default:            word = 64'h0;
        endcase
        if (q.idx >= cmd_len(q.cmd))
            read_byte = `READ_PAST_END;
        else
            read_byte = word[{q.idx, 3'h0} +: 8];
    endfunction : read_byte

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    assign scl_rise   = scl_sync & ~s.scl_d;
    assign scl_fall   = ~scl_sync & s.scl_d;
    assign start_seen = scl_sync & s.scl_d & s.sda_d & ~sda_sync;
    assign stop_seen  = scl_sync & s.scl_d & ~s.sda_d & sda_sync;

    always_comb begin
        logic       ack;
        logic [7:0] rb;
        logic [2:0] len;
        ack    = 1'b0;
        rb     = 8'h00;
        len    = cmd_len(s.cmd);
        next_s = s;
        next_s.scl_d = scl_sync;
        next_s.sda_d = sda_sync;

        // straps are caught once, on the first cycle after reset release
        if (!s.strap_taken) begin
            next_s.strap_taken = 1'b1;
            next_s.strap_pin_readback = strap_code;
            for (int p = 0; p < `NUM_PAGES; p++) begin
                next_s.loop_tuning_config[p] = strap_loop_tuning & `USED_LOOP_TUNING;
            end
        end

        next_s.snap = |(fault_event & ~s.snapshot_capture_fault_mask & `USED_SNAPSHOT_MASK);
        next_s.alert_oe = |(fault_class & ~s.alert_pin_fault_mask &
                            {7{`USED_ALERT_BYTE}});

        if (start_seen) begin
            // repeated start keeps the command so a read can follow it
            next_s.st        = LS_RECV;
            next_s.phase     = AF_ADDR;
            next_s.bitcnt    = 4'h0;
            next_s.idx       = 3'h0;
            next_s.sda_oe    = 1'b0;
            next_s.addressed = 1'b0;
        end else if (stop_seen) begin
            next_s.st     = LS_IDLE;
            next_s.sda_oe = 1'b0;
            // commit only a complete write; short or aborted ones leave the register alone
            if (s.addressed && !s.rw && s.phase == AF_DATA && s.idx == len) begin
                case (s.cmd)
                    `CMD_SNAPSHOT_MASK:
                        next_s.snapshot_capture_fault_mask =
                            s.wbuf[15:0] & `USED_SNAPSHOT_MASK;
                    // bits 5 and 7 of each byte kept zero
                    `CMD_ALERT_MASK:
                        next_s.alert_pin_fault_mask = s.wbuf & {7{`USED_ALERT_BYTE}};
                    `CMD_LOOP_TUNING: begin
                        next_s.loop_tuning_config[s.wpage] = s.wbuf[31:0] & `USED_LOOP_TUNING;
                        next_s.override[s.wpage]           = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end else begin
            case (s.st)
                LS_IDLE: begin
                    next_s.sda_oe = 1'b0;
                end
                LS_RECV: begin
                    if (scl_rise && s.bitcnt < `BYTE_BITS) begin
                        next_s.shreg  = {s.shreg[6:0], sda_sync};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (scl_fall && s.bitcnt == `BYTE_BITS) begin
                        case (s.phase)
                            AF_ADDR: begin
                                ack = (s.shreg[7:1] == `SMBUS_ADDR);
                                next_s.rw        = s.shreg[0];
                                next_s.addressed = ack;
                            end
                            AF_CMD: begin
                                ack = (cmd_len(s.shreg) != 3'h0);
                                next_s.cmd   = s.shreg;
                                next_s.wpage = page_sel;
                            end
                            AF_DATA: begin
                                ack = (s.cmd != `CMD_STRAP_READBACK) && (s.idx < len);
                                if (ack) begin
                                    next_s.wbuf[{s.idx, 3'h0} +: 8] = s.shreg;
                                    next_s.idx = s.idx + 3'h1;
                                end
                            end
                            default: ack = 1'b0;
                        endcase
                        next_s.sda_oe = ack;
                        next_s.st     = ack ? LS_ACK : LS_IDLE;
                        next_s.bitcnt = 4'h0;
                    end
                end
                LS_ACK: begin
                    if (scl_fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.st     = LS_RECV;
                        if (s.phase == AF_ADDR && s.rw) begin
                            rb            = read_byte(s, page_sel);
                            next_s.shreg  = rb;
                            next_s.sda_oe = ~rb[7];
                            next_s.bitcnt = 4'h1;
                            next_s.st     = LS_SEND;
                        end else if (s.phase == AF_ADDR) begin
                            next_s.phase = AF_CMD;
                        end else begin
                            next_s.phase = AF_DATA;
                            if (s.phase == AF_CMD)
                                next_s.idx = 3'h0;
                        end
                    end
                end
                LS_SEND: begin
                    if (scl_fall) begin
                        if (s.bitcnt < `BYTE_BITS) begin
                            next_s.sda_oe = ~s.shreg[3'h7 - s.bitcnt[2:0]];
                            next_s.bitcnt = s.bitcnt + 4'h1;
                        end else begin
                            next_s.sda_oe = 1'b0;
                            next_s.st     = LS_MACK;
                        end
                    end
                end
                LS_MACK: begin
                    if (scl_rise) begin
                        next_s.mack = ~sda_sync;
                    end else if (scl_fall) begin
                        if (s.mack) begin
                            next_s.idx    = s.idx + 3'h1;
                            rb            = read_byte(next_s, page_sel);
                            next_s.shreg  = rb;
                            next_s.sda_oe = ~rb[7];
                            next_s.bitcnt = 4'h1;
                            next_s.st     = LS_SEND;
                        end else begin
                            // master nack ends the read; bus released
                            next_s.st = LS_IDLE;
                        end
                    end
                end
                default: begin
                    next_s.st     = LS_IDLE;
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s                             <= '0;
            s.scl_d                       <= 1'b1;
            s.sda_d                       <= 1'b1;
            s.st                          <= LS_IDLE;
            s.phase                       <= AF_ADDR;
            s.snapshot_capture_fault_mask <= `RST_SNAPSHOT_MASK;
            s.alert_pin_fault_mask        <= `RST_ALERT_MASK;
        end else begin
            s <= next_s;
        end
    end

    // masks gate only these two outputs; fault inputs pass nowhere else
    assign snapshot_start       = s.snap;
    assign alert_output_pin.out = 1'b0;
    assign alert_output_pin.oe  = s.alert_oe;
    assign sda_drive.out        = 1'b0;
    assign sda_drive.oe         = s.sda_oe;

    // automatic loop values until the host overrides a page
    always_comb begin
        for (int p = 0; p < `NUM_PAGES; p++) begin
            if (s.override[p]) begin
                adaptive_loop_control[p].gain     = s.loop_tuning_config[p][15:0];
                adaptive_loop_control[p].residual = s.loop_tuning_config[p][23:16];
                adaptive_loop_control[p].enable   = s.loop_tuning_config[p][24];
            end else begin
                adaptive_loop_control[p].gain     = auto_gain;
                adaptive_loop_control[p].residual = auto_residual;
                adaptive_loop_control[p].enable   = 1'b1;
            end
        end
    end

endmodule : pmbus_fault_mask_strap_regs

// *** tb/pmbus_fault_mask_strap_regs_chk.sv ***
// assertions on the mask and strap bank ports
// assumes fault inputs are held at zero during reset
`timescale 1ns/1ns
`include "pmbus_fault_mask_strap_regs.svh"
module pmbus_fault_mask_strap_regs_chk (
    input wire logic                                       sys_clk,           // clock
    input wire logic                                       reset_n,           // reset
    input wire logic                                       scl_in,            // bus clock
    input wire logic                                       sda_in,            // bus data
    input pmbus_fault_mask_strap_pkg::pin_drive_t          sda_drive,         // data drive
    input pmbus_fault_mask_strap_pkg::pin_drive_t          alert_output_pin,  // alert drive
    input wire logic                                       page_sel,          // page
    input wire logic [15:0]                                fault_event,       // fault pulses
    input wire logic [55:0]                                fault_class,       // class bits
    input wire logic [47:0]                                strap_code,        // strap bytes
    input wire logic [31:0]                                strap_loop_tuning, // strap word
    input wire logic [15:0]                                auto_gain,         // auto gain
    input wire logic [7:0]                                 auto_residual,     // auto residual
    input wire logic                                       snapshot_start,    // capture pulse
    input pmbus_fault_mask_strap_pkg::loop_setting_t [1:0] adaptive_loop_control // loop
);
    import pmbus_fault_mask_strap_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // long high clock means no transfer is open
    sequence scl_idle;
        scl_in [*8];
    endsequence
    a_snap_has_cause: assert property (snapshot_start |-> $past(fault_event) != 16'h0000)
        else $error("capture started with no fault");
    a_snap_unused_quiet: assert property (
        (fault_event & `USED_SNAPSHOT_MASK) == 16'h0000 |=> !snapshot_start)
        else $error("capture from an unused fault bit");
    a_alert_has_cause: assert property (alert_output_pin.oe |-> $past(fault_class) != 56'h0)
        else $error("alert active with no fault class");
    a_alert_quiet: assert property (fault_class == 56'h0 |=> !alert_output_pin.oe)
        else $error("alert still active after classes cleared");
    a_reset_clear: assert property ($rose(reset_n) |->
        !snapshot_start && !alert_output_pin.oe && !sda_drive.oe)
        else $error("outputs active at reset release");
    a_alert_open_drain: assert property (alert_output_pin.out == 1'b0)
        else $error("alert pin driven high");
    a_sda_open_drain: assert property (sda_drive.out == 1'b0)
        else $error("data pin driven high");
    a_bus_idle_free: assert property (scl_idle |-> !sda_drive.oe)
        else $error("data held low on an idle bus");
endmodule : pmbus_fault_mask_strap_regs_chk

// *** tb/pmbus_host_model.sv ***
// bus host model: bit-banged writes and reads over open-drain lines
// assumes sda_wire is the pulled-up wired-and of every driver
`timescale 1ns/1ns
`include "pmbus_fault_mask_strap_regs.svh"
module pmbus_host_model (
    input  wire logic sys_clk,  // bench clock
    input  wire logic sda_wire, // resolved data line
    output logic      scl_line, // bus clock, idles high
    output logic      sda_host  // data drive, 1 releases
);
    initial begin
        scl_line = 1'b1;
        sda_host = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // low six cycles, high two: data settles long before the rising edge
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_host <= b;
        tick(4);
        scl_line <= 1'b1;
        tick(1);
        @(negedge sys_clk);
        r = sda_wire;
        tick(1);
        scl_line <= 1'b0;
    endtask : bit_io
    // waits for the slave to drop its ack before raising data
    task automatic start_cond;
        tick(6);
        sda_host <= 1'b1;
        tick(2);
        scl_line <= 1'b1;
        tick(2);
        sda_host <= 1'b0;
        tick(2);
        scl_line <= 1'b0;
    endtask : start_cond
    task automatic stop_cond;
        tick(2);
        sda_host <= 1'b0;
        tick(4);
        scl_line <= 1'b1;
        tick(2);
        sda_host <= 1'b1;
        tick(6);
    endtask : stop_cond
    task automatic put_byte(input logic [7:0] d, inout logic ok);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ok &= !r;
    endtask : put_byte
    // tuning words reach the device over this bus, or from the strap word at reset
    task automatic write_reg(input logic [7:0] cmd, input int len, input logic [55:0] d,
                             output logic ok);
        ok = 1'b1;
        start_cond();
        put_byte({`SMBUS_ADDR, 1'b0}, ok);
        put_byte(cmd, ok);
        for (int i = 0; i < len; i++) begin
            put_byte(d[8*i +: 8], ok);
        end
        stop_cond();
    endtask : write_reg
    task automatic read_reg(input logic [7:0] cmd, input int len, output logic [55:0] d,
                            output logic ok);
        logic r;
        ok = 1'b1;
        d = '1;
        start_cond();
        put_byte({`SMBUS_ADDR, 1'b0}, ok);
        put_byte(cmd, ok);
        start_cond();
        put_byte({`SMBUS_ADDR, 1'b1}, ok);
        for (int i = 0; i < len; i++) begin
            for (int j = 7; j >= 0; j--) begin
                bit_io(1'b1, r);
                d[8*i+j] = r;
            end
            bit_io(i == len - 1, r);
        end
        stop_cond();
    endtask : read_reg
endmodule : pmbus_host_model

// *** tb/tb_pmbus_fault_mask_strap_regs.sv ***
// bench for the mask and strap register bank, traffic through the bus host model
// assumes the host model and checker are compiled ahead of this file
`timescale 1ns/1ns
`include "pmbus_fault_mask_strap_regs.svh"
module tb_pmbus_fault_mask_strap_regs;
    import pmbus_fault_mask_strap_pkg::*;
    localparam logic [47:0] STRAPS     = 48'h1ef1f2f3000a;
    localparam logic [31:0] TUNE_STRAP = 32'h014000c8;
    localparam logic [15:0] AUTO_GAIN  = 16'h0100;
    localparam logic [7:0]  AUTO_RES   = 8'h33;
    localparam logic [15:0] SNAP_MASK  = 16'h2855;
    localparam logic [15:0] SNAP_EXP   = `USED_SNAPSHOT_MASK & ~SNAP_MASK;
    localparam logic [55:0] ALERT_MASK = 56'h4a15401f005f06;
    // class bits outside the used set never reach the alert pin
    localparam logic [7:0]  ALERT_USED = `USED_ALERT_BYTE;
    logic                sys_clk = 1'b0;
    logic                reset_n;
    logic                scl_line;
    logic                sda_host;
    logic                sda_in;
    logic                page_sel;
    logic                snapshot_start;
    logic [15:0]         fault_event;
    logic [55:0]         fault_class;
    pin_drive_t          sda_drive;
    pin_drive_t          alert_pin;
    loop_setting_t [1:0] loop_ctl;
    int                  bad_count = 0;
    int                  n_compared = 0;

    always #50 sys_clk = ~sys_clk;
    assign sda_in = sda_host & ~sda_drive.oe;

    pmbus_host_model i_pmbus_host_model (
        .sys_clk(sys_clk), .sda_wire(sda_in), .scl_line(scl_line), .sda_host(sda_host)
    );
    pmbus_fault_mask_strap_regs i_pmbus_fault_mask_strap_regs (
        .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_line), .sda_in(sda_in),
        .sda_drive(sda_drive), .alert_output_pin(alert_pin), .page_sel(page_sel),
        .fault_event(fault_event), .fault_class(fault_class), .strap_code(STRAPS),
        .strap_loop_tuning(TUNE_STRAP), .auto_gain(AUTO_GAIN), .auto_residual(AUTO_RES),
        .snapshot_start(snapshot_start), .adaptive_loop_control(loop_ctl)
    );

    task automatic cmp_word(input logic [55:0] got, input logic [55:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_flag(input logic got, input logic exp, input string what);
        cmp_word({55'h0, got}, {55'h0, exp}, what);
    endtask : cmp_flag
    // only the bytes of the command length are compared
    task automatic rd(input logic [7:0] cmd, input int len, input logic [55:0] exp);
        logic [55:0] d;
        logic        ok;
        logic [55:0] keep;
        keep = (56'h1 << (8 * len)) - 56'h1;
        i_pmbus_host_model.read_reg(cmd, len, d, ok);
        cmp_flag(ok, 1'b1, "read ack");
        cmp_word(d & keep, exp & keep, "read data");
    endtask : rd
    task automatic wr(input logic [7:0] cmd, input int len, input logic [55:0] d, input logic ok_exp);
        logic ok;
        i_pmbus_host_model.write_reg(cmd, len, d, ok);
        cmp_flag(ok, ok_exp, "write ack");
    endtask : wr
    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        #3_000_000;
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        reset_n = 1'b0;
        page_sel = 1'b0;
        fault_event = 16'h0000;
        fault_class = 56'h0;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(`CMD_SNAPSHOT_MASK, 2, 56'h0);
        rd(`CMD_ALERT_MASK, 7, `RST_ALERT_MASK);
        rd(`CMD_STRAP_READBACK, 7, {STRAPS, `STRAP_UNUSED_BYTE});
        wr(`CMD_STRAP_READBACK, 1, 56'h0, 1'b0);
        rd(`CMD_STRAP_READBACK, 7, {STRAPS, `STRAP_UNUSED_BYTE});
        wr(8'hd8, 2, 56'h0, 1'b0);
        rd(`CMD_LOOP_TUNING, 4, {24'h0, TUNE_STRAP});
        cmp_word({31'h0, loop_ctl[0]}, {31'h0, AUTO_GAIN, AUTO_RES, 1'b1}, "auto loop");
        wr(`CMD_SNAPSHOT_MASK, 2, 56'hffff, 1'b1);
        rd(`CMD_SNAPSHOT_MASK, 2, {40'h0, `USED_SNAPSHOT_MASK});
        wr(`CMD_SNAPSHOT_MASK, 2, {40'h0, SNAP_MASK | 16'h0200}, 1'b1);
        rd(`CMD_SNAPSHOT_MASK, 2, {40'h0, SNAP_MASK});
        for (int i = 0; i < 16; i++) begin
            fault_event <= 16'h0001 << i;
            @(posedge sys_clk);
            fault_event <= 16'h0000;
            @(negedge sys_clk);
            cmp_flag(snapshot_start, SNAP_EXP[i], "capture start");
            @(posedge sys_clk);
        end
        wr(`CMD_ALERT_MASK, 7, ALERT_MASK | {7{8'ha0}}, 1'b1);
        rd(`CMD_ALERT_MASK, 7, ALERT_MASK);
        // the capture mask is still set here, so the alert path runs beside it
        for (int i = 0; i < 56; i++) begin
            if (i % 8 != 5) begin
                fault_class <= 56'h1 << i;
                @(posedge sys_clk);
                @(negedge sys_clk);
                cmp_flag(alert_pin.oe, ~ALERT_MASK[i] & ALERT_USED[i % 8], "alert pin");
                @(posedge sys_clk);
                fault_class <= 56'h0;
                @(posedge sys_clk);
            end
        end
        page_sel <= 1'b0;
        wr(`CMD_LOOP_TUNING, 4, 56'hff5a012c, 1'b1);
        cmp_word({31'h0, loop_ctl[1]}, {31'h0, AUTO_GAIN, AUTO_RES, 1'b1}, "page 1 auto");
        page_sel <= 1'b1;
        wr(`CMD_LOOP_TUNING, 4, 56'hff5a012c, 1'b1);
        rd(`CMD_LOOP_TUNING, 4, 56'h015a012c);
        cmp_word({31'h0, loop_ctl[1]}, {31'h0, 16'h012c, 8'h5a, 1'b1}, "page 1 loop");
        cmp_word({31'h0, loop_ctl[0]}, {31'h0, 16'h012c, 8'h5a, 1'b1}, "page 0 loop");
        final_report();
    end
endmodule : tb_pmbus_fault_mask_strap_regs

bind pmbus_fault_mask_strap_regs pmbus_fault_mask_strap_regs_chk
    i_pmbus_fault_mask_strap_regs_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_drive(sda_drive), .alert_output_pin(alert_output_pin), .page_sel(page_sel),
    .fault_event(fault_event), .fault_class(fault_class), .strap_code(strap_code),
    .strap_loop_tuning(strap_loop_tuning), .auto_gain(auto_gain),
    .auto_residual(auto_residual), .snapshot_start(snapshot_start),
    .adaptive_loop_control(adaptive_loop_control)
);
